// [logic/segment_lcd_driver_control.sv]
// What this block does
// - Display off holds every common and segment output at supply level.
// - Wave-type bit picks waveform A at 0, waveform B at 1.
// - Bias code 00 half, 01 third, upper bit set quarter bias.
// - Duty code picks static, 1/3, 1/4 or 1/8; sets commons scanned.
// - Frame code 00 phases last 512, 172, 128, 64 sub-clock cycles.
// - Frame code 01 phases last 560, 188, 140, 70 sub-clock cycles.
// - Frame code 10 phases last 608, 204, 152, 76 sub-clock cycles.
// - Frame code 11 phases last 464, 156, 116, 58 sub-clock cycles.
// - Pointer holds five address bits; upper three bits read zero.
// - Window register reads and writes the RAM byte the pointer selects.
// - Drive-clock code divides core clock by 2^9, 2^8, 2^7, 2^6.
// - Three-bit contrast code selects one of eight output voltage ranges.
// - Each common-enable bit set makes its pin a common driver.
//
// The implementer's own choice: the Avalon-MM slave port.
module segment_lcd_driver_control
  import lcd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        sub_clock,
  input  wire logic        sub_osc_running,
  output glass_drive_t     glass
);

`include "lcd_map.svh"

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  display_control_t ctrl_reg;
  display_control_t ctrl_next;
  logic [4:0]       ram_pointer_reg;
  logic [4:0]       ram_pointer_next;
  clock_contrast_t  vcr_reg;
  clock_contrast_t  vcr_next;
  logic [7:0]       common_line_enables_reg;
  logic [7:0]       common_line_enables_next;
  logic [7:0]       ram_reg [23];
  logic [7:0]       ram_next [23];
  logic             ack_reg;
  logic             ack_next;
  logic [31:0]      readdata_reg;
  logic [31:0]      readdata_next;
  logic             req;
  logic             accept;
  logic             wr_lane;
  logic [3:0]       reg_index;
  logic             ptr_valid;
  logic [7:0]       ram_window_byte;

  assign req         = read || write;
  assign waitrequest = req && !ack_reg;
  assign accept      = req && ack_reg;
  assign readdata    = readdata_reg;

  always_comb begin
    reg_index                = address[5:2];
    wr_lane                  = accept && write && byteenable[0];
    ptr_valid                = ram_pointer_reg < `RAM_DEPTH;
    ram_window_byte          = ptr_valid ? ram_reg[ram_pointer_reg] : 8'h00;
    ack_next                 = req && !ack_reg;
    readdata_next            = readdata_reg;
    ctrl_next                = ctrl_reg;
    ram_pointer_next         = ram_pointer_reg;
    vcr_next                 = vcr_reg;
    common_line_enables_next = common_line_enables_reg;
    ram_next                 = ram_reg;
    if (req && !ack_reg) begin
      readdata_next = 32'h0000_0000;
      if (address[1:0] == 2'b00) begin
        unique case (reg_index)
          `IDX_DISPLAY_CONTROL: readdata_next[7:0] = ctrl_reg;
          `IDX_RAM_POINTER:     readdata_next[7:0] = {3'b000, ram_pointer_reg};
          `IDX_RAM_WINDOW:      readdata_next[7:0] = ram_window_byte;
          `IDX_CLOCK_CONTRAST:  readdata_next[7:0] = vcr_reg & `CLOCK_CONTRAST_MASK;
          `IDX_COMMON_ENABLES:  readdata_next[7:0] = common_line_enables_reg;
          default:              readdata_next      = 32'h0000_0000;
        endcase
      end
    end
    if (wr_lane && address[1:0] == 2'b00) begin
      unique case (reg_index)
        `IDX_DISPLAY_CONTROL: ctrl_next = writedata[7:0];
        `IDX_RAM_POINTER:     ram_pointer_next = writedata[4:0];
        `IDX_RAM_WINDOW: begin
          if (ptr_valid) begin
            ram_next[ram_pointer_reg] = writedata[7:0];
          end
        end
        `IDX_CLOCK_CONTRAST:  vcr_next = writedata[7:0] & `CLOCK_CONTRAST_MASK;
        `IDX_COMMON_ENABLES:  common_line_enables_next = writedata[7:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_reg                 <= 1'b0;
      readdata_reg            <= 32'h0000_0000;
      ctrl_reg                <= `RST_DISPLAY_CONTROL;
      ram_pointer_reg         <= `RST_RAM_POINTER;
      vcr_reg                 <= `RST_CLOCK_CONTRAST;
      common_line_enables_reg <= `RST_COMMON_ENABLES;
      for (int i = 0; i < 23; i++) begin
        ram_reg[i] <= `RST_RAM_BYTE;
      end
    end else begin
      ack_reg                 <= ack_next;
      readdata_reg            <= readdata_next;
      ctrl_reg                <= ctrl_next;
      ram_pointer_reg         <= ram_pointer_next;
      vcr_reg                 <= vcr_next;
      common_line_enables_reg <= common_line_enables_next;
      ram_reg                 <= ram_next;
    end
  end

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  logic [9:0]  div_period;
  logic [9:0]  div_count;
  logic        drive_tick;
  logic [9:0]  phase_period;
  logic [9:0]  phase_count;
  logic        phase_wrap;
  logic        sub_prev_reg;
  logic        sub_prev_next;
  logic        time_tick;
  logic        scan_clear;

  always_comb begin
    unique case (vcr_reg.drive_clock_divider)
      2'b00: div_period = `DIV_CODE0;
      2'b01: div_period = `DIV_CODE1;
      2'b10: div_period = `DIV_CODE2;
      2'b11: div_period = `DIV_CODE3;
    endcase
    unique case ({ctrl_reg.frame_rate_select, ctrl_reg.duty_select})
      4'h0: phase_period = `PH_F0_STATIC;
      4'h1: phase_period = `PH_F0_THIRD;
      4'h2: phase_period = `PH_F0_QUART;
      4'h3: phase_period = `PH_F0_EIGHTH;
      4'h4: phase_period = `PH_F1_STATIC;
      4'h5: phase_period = `PH_F1_THIRD;
      4'h6: phase_period = `PH_F1_QUART;
      4'h7: phase_period = `PH_F1_EIGHTH;
      4'h8: phase_period = `PH_F2_STATIC;
      4'h9: phase_period = `PH_F2_THIRD;
      4'ha: phase_period = `PH_F2_QUART;
      4'hb: phase_period = `PH_F2_EIGHTH;
      4'hc: phase_period = `PH_F3_STATIC;
      4'hd: phase_period = `PH_F3_THIRD;
      4'he: phase_period = `PH_F3_QUART;
      4'hf: phase_period = `PH_F3_EIGHTH;
    endcase
    sub_prev_next = sub_clock;
    // Without a running sub-oscillator the divided core clock paces the scan
    time_tick = sub_osc_running ? (sub_clock && !sub_prev_reg) : drive_tick;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sub_prev_reg <= 1'b0;
    end else begin
      sub_prev_reg <= sub_prev_next;
    end
  end

  lcd_tick_counter u_drive_div (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clear   (1'b0),
    .tick    (1'b1),
    .period  (div_period),
    .count   (div_count),
    .wrap    (drive_tick)
  );

  lcd_tick_counter u_phase (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clear   (scan_clear),
    .tick    (time_tick),
    .period  (phase_period),
    .count   (phase_count),
    .wrap    (phase_wrap)
  );

  // ----------------------------------------
  // Common scan
  // ----------------------------------------
  scan_state_t state_reg;
  scan_state_t state_next;
  logic [2:0]  phase_reg;
  logic [2:0]  phase_next;
  logic        frame_pol_reg;
  logic        frame_pol_next;
  logic [2:0]  last_phase;

  always_comb begin
    unique case (ctrl_reg.duty_select)
      2'b00: last_phase = 3'h0;
      2'b01: last_phase = 3'h2;
      2'b10: last_phase = 3'h3;
      2'b11: last_phase = 3'h7;
    endcase
    scan_clear     = state_reg == ST_OFF;
    state_next     = ctrl_reg.display_on ? ST_SCAN : ST_OFF;
    phase_next     = phase_reg;
    frame_pol_next = frame_pol_reg;
    unique case (state_reg)
      ST_OFF: begin
        phase_next     = 3'h0;
        frame_pol_next = 1'b0;
      end
      ST_SCAN: begin
        if (phase_reg > last_phase) begin
          phase_next = 3'h0;
        end else if (phase_wrap) begin
          if (phase_reg == last_phase) begin
            phase_next     = 3'h0;
            frame_pol_next = !frame_pol_reg;
          end else begin
            phase_next = phase_reg + 3'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg     <= ST_OFF;
      phase_reg     <= 3'h0;
      frame_pol_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      phase_reg     <= phase_next;
      frame_pol_reg <= frame_pol_next;
    end
  end

  // ----------------------------------------
  // Pin levels
  // ----------------------------------------
  glass_drive_t glass_reg;
  glass_drive_t glass_next;
  level_t       steps;
  logic         pol;

  always_comb begin
    steps = ctrl_reg.bias_select[1] ? 3'h4 : (ctrl_reg.bias_select[0] ? 3'h3 : 3'h2);
    pol   = ctrl_reg.drive_wave_type ? frame_pol_reg
                                     : (phase_count >= {1'b0, phase_period[9:1]});
    glass_next                 = glass_reg;
    glass_next.bias_steps      = steps;
    glass_next.contrast_level  = vcr_reg.contrast_level;
    glass_next.common_drive_en = common_line_enables_reg;
    for (int c = 0; c < 8; c++) begin
      if (state_reg != ST_SCAN) begin
        glass_next.common_level[c] = steps;
      end else if (c == int'(phase_reg)) begin
        glass_next.common_level[c] = pol ? steps : 3'h0;
      end else begin
        glass_next.common_level[c] = pol ? 3'h1 : steps - 3'h1;
      end
    end
    for (int s = 0; s < 23; s++) begin
      if (state_reg != ST_SCAN) begin
        glass_next.segment_line[s] = steps;
      end else if (ram_reg[s][phase_reg]) begin
        glass_next.segment_line[s] = pol ? 3'h0 : steps;
      end else begin
        glass_next.segment_line[s] = pol ? steps - 3'h1 : 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      glass_reg <= '0;
    end else begin
      glass_reg <= glass_next;
    end
  end

  assign glass = glass_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_window_write;
    accept && write && byteenable[0] && address == {`IDX_RAM_WINDOW, 2'b00} && ptr_valid;
  endsequence

  a_off_supply: assert property (state_reg == ST_OFF ##1 state_reg == ST_OFF |->
    glass.common_level[3] == glass.bias_steps && glass.segment_line[9] == glass.bias_steps)
    else $error("outputs not at supply while off");
  a_wave_b_steady: assert property (ctrl_reg.drive_wave_type && state_reg == ST_SCAN
    && !phase_wrap ##1 ctrl_reg.drive_wave_type |-> pol == $past(pol))
    else $error("type B polarity moved inside frame");
  a_bias_steps: assert property ($stable(ctrl_reg) [*3] |->
    glass.bias_steps == (ctrl_reg.bias_select == 2'b00 ? 3'h2 :
                         ctrl_reg.bias_select == 2'b01 ? 3'h3 : 3'h4))
    else $error("bias steps wrong");
  a_duty_bound: assert property (state_reg == ST_SCAN && $stable(ctrl_reg) |=>
    phase_reg <= $past(last_phase)) else $error("phase beyond duty");
  a_rate_f0: assert property (phase_wrap && ctrl_reg[3:0] == 4'h4 |->
    phase_count == 10'h0ab) else $error("frame code 0 phase length");
  a_rate_f1: assert property (phase_wrap && ctrl_reg[3:0] == 4'h9 |->
    phase_count == 10'h08b) else $error("frame code 1 phase length");
  a_rate_f2: assert property (phase_wrap && ctrl_reg[3:0] == 4'he |->
    phase_count == 10'h04b) else $error("frame code 2 phase length");
  a_rate_f3: assert property (phase_wrap && ctrl_reg[3:0] == 4'h3 |->
    phase_count == 10'h1cf) else $error("frame code 3 phase length");
  a_window_write: assert property (s_window_write |=>
    ram_reg[$past(ram_pointer_reg)] == $past(writedata[7:0]))
    else $error("window write lost");
  a_pointer_zero: assert property (accept && read &&
    address == {`IDX_RAM_POINTER, 2'b00} |-> readdata[31:5] == 27'h0)
    else $error("pointer upper bits not zero");
  a_window_read: assert property (accept && read &&
    address == {`IDX_RAM_WINDOW, 2'b00} |-> readdata[7:0] == ram_window_byte)
    else $error("window read wrong");
  a_div_length: assert property (drive_tick && $stable(vcr_reg.drive_clock_divider)
    && vcr_reg.drive_clock_divider == 2'b11 |-> div_count == 10'h03f)
    else $error("drive clock division wrong");
  a_scan_step: assert property (phase_wrap && state_reg == ST_SCAN
    && phase_reg < last_phase && $stable(ctrl_reg) |=> phase_reg == $past(phase_reg) + 3'h1)
    else $error("scan not ascending");

endmodule : segment_lcd_driver_control

// [inc/lcd_map.svh]
`ifndef LCD_MAP_SVH
`define LCD_MAP_SVH

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define IDX_DISPLAY_CONTROL   4'h5
`define IDX_RAM_POINTER       4'h6
`define IDX_RAM_WINDOW        4'h7
`define IDX_CLOCK_CONTRAST    4'h8
`define IDX_COMMON_ENABLES    4'h9

// ----------------------------------------
// Field masks and reset values
// ----------------------------------------
`define POINTER_MASK          8'h1f
`define CLOCK_CONTRAST_MASK   8'h1f
`define RST_DISPLAY_CONTROL   8'h00
`define RST_RAM_POINTER       5'h00
`define RST_CLOCK_CONTRAST    8'h00
`define RST_COMMON_ENABLES    8'h00
`define RST_RAM_BYTE          8'h00
`define RAM_DEPTH             5'h17

// ----------------------------------------
// Common phase lengths in time-base ticks
// ----------------------------------------
`define PH_F0_STATIC 10'h200
`define PH_F0_THIRD  10'h0ac
`define PH_F0_QUART  10'h080
`define PH_F0_EIGHTH 10'h040
`define PH_F1_STATIC 10'h230
`define PH_F1_THIRD  10'h0bc
`define PH_F1_QUART  10'h08c
`define PH_F1_EIGHTH 10'h046
`define PH_F2_STATIC 10'h260
`define PH_F2_THIRD  10'h0cc
`define PH_F2_QUART  10'h098
`define PH_F2_EIGHTH 10'h04c
`define PH_F3_STATIC 10'h1d0
`define PH_F3_THIRD  10'h09c
`define PH_F3_QUART  10'h074
`define PH_F3_EIGHTH 10'h03a

// ----------------------------------------
// Drive clock division of the core clock
// ----------------------------------------
`define DIV_CODE0 10'h200
`define DIV_CODE1 10'h100
`define DIV_CODE2 10'h080
`define DIV_CODE3 10'h040

`endif

// [inc/lcd_pkg.sv]
package lcd_pkg;

  // ----------------------------------------
  // Register layouts
  // ----------------------------------------
  typedef struct packed {
    logic       display_on;
    logic       drive_wave_type;
    logic [1:0] bias_select;
    logic [1:0] duty_select;
    logic [1:0] frame_rate_select;
  } display_control_t;

  typedef struct packed {
    logic [2:0] reserved;
    logic [1:0] drive_clock_divider;
    logic [2:0] contrast_level;
  } clock_contrast_t;

  // ----------------------------------------
  // Pin levels toward the glass
  // ----------------------------------------
  typedef logic [2:0] level_t;

  typedef struct packed {
    level_t [7:0]  common_level;
    level_t [22:0] segment_line;
    logic   [7:0]  common_drive_en;
    level_t        bias_steps;
    logic   [2:0]  contrast_level;
  } glass_drive_t;

  typedef enum logic [1:0] {
    ST_OFF  = 2'b01,
    ST_SCAN = 2'b10
  } scan_state_t;

endpackage : lcd_pkg

// [logic/lcd_tick_counter.sv]
module lcd_tick_counter (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       tick,
  input  wire logic [9:0] period,
  output logic      [9:0] count,
  output logic            wrap
);

  logic [9:0] count_reg;
  logic [9:0] count_next;

  // ----------------------------------------
  // Count ticks, wrap after period ticks
  // ----------------------------------------
  always_comb begin
    wrap       = tick && !clear && (count_reg >= period - 10'h001);
    count_next = count_reg;
    if (clear || wrap) begin
      count_next = 10'h000;
    end else if (tick) begin
      count_next = count_reg + 10'h001;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_reg <= 10'h000;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

endmodule : lcd_tick_counter

// [dv/lcd_glass_model.sv]
// ----------------------------------------
// Passive glass: finds the selected common and times each phase
// ----------------------------------------
module lcd_glass_model
  import lcd_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire glass_drive_t glass,
  output logic [2:0]        sel_idx,
  output logic              sel_high,
  output logic              seen,
  output logic [15:0]       phase_len
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0]  idx_now;
  logic        high_now;
  logic [15:0] cnt;

  // Selected common sits at an outer level, others inside
  always_comb begin
    idx_now  = 3'h0;
    high_now = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (glass.common_level[i] == 3'h0 || glass.common_level[i] == glass.bias_steps) begin
        idx_now  = 3'(i);
        high_now = (glass.common_level[i] == glass.bias_steps);
      end
    end
  end

  // A phase ends when the selected common or its level changes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel_idx   <= 3'h0;
      sel_high  <= 1'b0;
      seen      <= 1'b0;
      phase_len <= 16'h0;
      cnt       <= 16'h0;
    end else begin
      seen <= 1'b0;
      cnt  <= cnt + 16'h1;
      if (idx_now != sel_idx || high_now != sel_high) begin
        seen      <= 1'b1;
        phase_len <= cnt + 16'h1;
        cnt       <= 16'h0;
        sel_idx   <= idx_now;
        sel_high  <= high_now;
      end
    end
  end
endmodule : lcd_glass_model

// [dv/segment_lcd_driver_control_tb_top.sv]
`include "lcd_map.svh"
module segment_lcd_driver_control_tb_top import lcd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic         clk_sys, rst, read, write, waitrequest, sub_clock, sub_osc_running, sub_div;
  logic  [5:0]  address;
  logic  [31:0] writedata, readdata, rd;
  logic  [3:0]  byteenable;
  glass_drive_t glass;
  logic  [2:0]  sel_idx;
  logic         sel_high, seen;
  logic  [15:0] phase_len, lfsr;
  logic  [7:0]  ram_model [23];
  int           err_count, compares, cycles;
  int ph_table [4][4] = '{'{512, 172, 128, 64}, '{560, 188, 140, 70},
                          '{608, 204, 152, 76}, '{464, 156, 116, 58}};
  int ncom [4]     = '{1, 3, 4, 8};
  int steps_of [4] = '{2, 3, 4, 4};

  segment_lcd_driver_control segment_lcd_driver_control_inst (
    .clk_sys(clk_sys), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .sub_clock(sub_clock), .sub_osc_running(sub_osc_running),
    .glass(glass));

  lcd_glass_model lcd_glass_model_inst (
    .clk_sys(clk_sys), .rst(rst), .glass(glass), .sel_idx(sel_idx),
    .sel_high(sel_high), .seen(seen), .phase_len(phase_len));

  // ----------------------------------------
  // Clocks and timeout
  // ----------------------------------------
  always #20 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    sub_div <= ~sub_div;
    if (sub_div) sub_clock <= ~sub_clock;
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      err_count++;
      final_report();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    compares++;
    if (seen_v !== exp_v) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask : check

  task automatic final_report();
    $display("errors=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic wait_accept();
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (waitrequest !== 1'b0);
    check(k, 2);
  endtask : wait_accept

  task automatic reg_write(input logic [3:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    address    <= {idx, 2'b00};
    writedata  <= {24'h0, d};
    byteenable <= 4'h1;
    write      <= 1'b1;
    wait_accept();
    write <= 1'b0;
  endtask : reg_write

  task automatic read_check(input logic [3:0] idx, input logic [7:0] exp_v);
    @(posedge clk_sys);
    address <= {idx, 2'b00};
    read    <= 1'b1;
    wait_accept();
    rd = readdata;
    read <= 1'b0;
    check(rd, {24'h0, exp_v});
  endtask : read_check

  task automatic next_phase();
    do @(posedge clk_sys); while (seen !== 1'b1);
  endtask : next_phase

  task automatic run_phase(input logic [1:0] f, input logic [1:0] d, input logic [1:0] b,
                           input logic wave, input int exp_len);
    logic [2:0] prev, st, on_l, off_l;
    reg_write(`IDX_DISPLAY_CONTROL, 8'h00);
    reg_write(`IDX_DISPLAY_CONTROL, {1'b1, wave, b, d, f});
    read_check(`IDX_DISPLAY_CONTROL, {1'b1, wave, b, d, f});
    next_phase();
    next_phase();
    prev = sel_idx;
    next_phase();
    check(phase_len, exp_len);
    if (wave) check(sel_idx, (prev + 1) % ncom[d]);
    st    = 3'(steps_of[b]);
    on_l  = sel_high ? 3'h0 : st;
    off_l = sel_high ? st - 3'h1 : 3'h1;
    check(glass.bias_steps, st);
    for (int s = 0; s < 23; s++) begin
      check(glass.segment_line[s], ram_model[s][sel_idx] ? on_l : off_l);
    end
  endtask : run_phase

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk_sys = 0; rst = 1; read = 0; write = 0; address = 0; writedata = 0;
    byteenable = 0; sub_clock = 0; sub_div = 0; sub_osc_running = 1;
    lfsr = 16'he0f8; err_count = 0; compares = 0; cycles = 0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 5; i < 10; i++) read_check(4'(i), 8'h00);
    reg_write(4'h4, 8'h5a);
    read_check(4'h4, 8'h00);
    for (int b = 0; b < 4; b++) begin
      reg_write(`IDX_DISPLAY_CONTROL, {2'b00, 2'(b), 4'h0});
      repeat (3) @(posedge clk_sys);
      check(glass.bias_steps, steps_of[b]);
      for (int i = 0; i < 8; i++) check(glass.common_level[i], steps_of[b]);
      for (int s = 0; s < 23; s++) check(glass.segment_line[s], steps_of[b]);
    end
    for (int c = 0; c < 8; c++) begin
      reg_write(`IDX_CLOCK_CONTRAST, {3'b000, lfsr[1:0], 3'(c)});
      read_check(`IDX_CLOCK_CONTRAST, {3'b000, lfsr[1:0], 3'(c)});
      repeat (3) @(posedge clk_sys);
      check(glass.contrast_level, c);
      lfsr = lfsr_next(lfsr);
    end
    reg_write(`IDX_COMMON_ENABLES, lfsr[7:0]);
    read_check(`IDX_COMMON_ENABLES, lfsr[7:0]);
    repeat (3) @(posedge clk_sys);
    check(glass.common_drive_en, lfsr[7:0]);
    reg_write(`IDX_RAM_POINTER, 8'hff);
    read_check(`IDX_RAM_POINTER, 8'h1f);
    for (int a = 0; a < 23; a++) begin
      lfsr = lfsr_next(lfsr);
      ram_model[a] = lfsr[7:0];
      reg_write(`IDX_RAM_POINTER, 8'(a));
      reg_write(`IDX_RAM_WINDOW, ram_model[a]);
    end
    for (int a = 22; a >= 0; a--) begin
      reg_write(`IDX_RAM_POINTER, 8'(a));
      read_check(`IDX_RAM_WINDOW, ram_model[a]);
    end
    reg_write(`IDX_RAM_POINTER, 8'h17);
    reg_write(`IDX_RAM_WINDOW, 8'hff);
    read_check(`IDX_RAM_WINDOW, 8'h00);
    for (int f = 0; f < 4; f++) begin
      for (int d = 0; d < 4; d++) begin
        run_phase(2'(f), 2'(d), 2'(f + d), 1'b1, ph_table[f][d] * 4);
      end
    end
    run_phase(2'h3, 2'h3, 2'h0, 1'b0, 29 * 4);
    sub_osc_running <= 1'b0;
    reg_write(`IDX_CLOCK_CONTRAST, 8'h18);
    run_phase(2'h3, 2'h3, 2'h1, 1'b1, 58 * 64);
    final_report();
  end
endmodule : segment_lcd_driver_control_tb_top
